// ### core/vofs_top.sv
module vofs_top (
   input  wire logic                         MCLK,
   input  wire logic                         ARST_N,
   input  wire logic [vofs_pkg::ADDR_W-1:0]  AVS_ADDRESS,
   input  wire logic                         AVS_READ,
   input  wire logic                         AVS_WRITE,
   input  wire logic [vofs_pkg::DATA_W-1:0]  AVS_WRITEDATA,
   input  wire logic [3:0]                   AVS_BYTEENABLE,
   output logic      [vofs_pkg::DATA_W-1:0]  AVS_READDATA,
   output logic                              AVS_WAITREQUEST,
   output logic      [vofs_pkg::CODE_W-1:0]  PORT178_FUNCTION_CODE,
   output logic      [vofs_pkg::CODE_W-1:0]  PORT179_FUNCTION_CODE,
   output logic      [vofs_pkg::CODE_W-1:0]  PORT180_FUNCTION_CODE,
   output logic      [vofs_pkg::CODE_W-1:0]  PORT181_FUNCTION_CODE
);
   import vofs_pkg::*;

   // both fields must sit inside the two low byte lanes
   if (LO_POS + CODE_W > 8 || HI_POS < 8 || HI_POS + CODE_W > 16
       || PORT_CNT != 4)
      $error("vofs_top: field layout does not fit two byte lanes");

   typedef struct packed {
      logic [PORT_CNT-1:0][CODE_W-1:0] code;
      logic                            done;
      logic [DATA_W-1:0]               rdata;
   } vofs_state_t;

   vofs_state_t st;
   vofs_state_t next_st;
   logic        rst_meta;
   logic        rst_sync;

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // register image with unimplemented bits forced to zero
   function automatic logic [DATA_W-1:0] image(
      input logic [CODE_W-1:0] hi,
      input logic [CODE_W-1:0] lo
   );
      image = '0;
      image[HI_POS +: CODE_W] = hi;
      image[LO_POS +: CODE_W] = lo;
   endfunction

   // register number: 0 select_a, 1 select_b, 2 nothing mapped
   function automatic logic [1:0] reg_index(
      input logic [ADDR_W-1:0] a
   );
      case (a)
         OFS_SELECT_A: reg_index = 2'h0;
         OFS_SELECT_B: reg_index = 2'h1;
         default:      reg_index = 2'h2;
      endcase
   endfunction

   logic req;
   assign req = (AVS_READ || AVS_WRITE) && !st.done;

   always_comb begin
      next_st      = st;
      next_st.done = req;
      if (req && AVS_WRITE) begin
         // only fields are stored; bits 7:6, 15:14 are dropped
         case (reg_index(AVS_ADDRESS))
            2'h0: begin
               if (AVS_BYTEENABLE[0])
                  next_st.code[0] = AVS_WRITEDATA[LO_POS +: CODE_W];
               if (AVS_BYTEENABLE[1])
                  next_st.code[1] = AVS_WRITEDATA[HI_POS +: CODE_W];
            end
            2'h1: begin
               if (AVS_BYTEENABLE[0])
                  next_st.code[2] = AVS_WRITEDATA[LO_POS +: CODE_W];
               if (AVS_BYTEENABLE[1])
                  next_st.code[3] = AVS_WRITEDATA[HI_POS +: CODE_W];
            end
            default: begin
               // stray address: acknowledged, nothing stored
               next_st.code = st.code;
            end
         endcase
      end
      if (req && AVS_READ) begin
         case (reg_index(AVS_ADDRESS))
            2'h0:
               next_st.rdata = image(st.code[1], st.code[0]);
            2'h1:
               next_st.rdata = image(st.code[3], st.code[2]);
            default:
               next_st.rdata = UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         st.code  <= {PORT_CNT{CODE_RESET}};
         st.done  <= 1'b0;
         st.rdata <= '0;
      end else begin
         st <= next_st;
      end
   end

   // virtual ports: internal function codes only, no pad
   assign PORT178_FUNCTION_CODE = st.code[0];
   assign PORT179_FUNCTION_CODE = st.code[1];
   assign PORT180_FUNCTION_CODE = st.code[2];
   assign PORT181_FUNCTION_CODE = st.code[3];
   assign AVS_READDATA          = st.rdata;
   assign AVS_WAITREQUEST       = !st.done;

   // write path
   chk_hi_a_write: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_WRITE && AVS_ADDRESS == OFS_SELECT_A && AVS_BYTEENABLE[1])
      |=> PORT179_FUNCTION_CODE == $past(AVS_WRITEDATA[13:8]))
      else $error("port 179 code not taken from bits 13:8");
   chk_lo_a_write: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_WRITE && AVS_ADDRESS == OFS_SELECT_A && AVS_BYTEENABLE[0])
      |=> PORT178_FUNCTION_CODE == $past(AVS_WRITEDATA[5:0]))
      else $error("port 178 code not taken from bits 5:0");
   chk_b_write: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_WRITE && AVS_ADDRESS == OFS_SELECT_B
       && AVS_BYTEENABLE == 4'hF)
      |=> PORT181_FUNCTION_CODE == $past(AVS_WRITEDATA[13:8])
       && PORT180_FUNCTION_CODE == $past(AVS_WRITEDATA[5:0]))
      else $error("select_b fields not stored");
   chk_lo_b_write: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_WRITE && AVS_ADDRESS == OFS_SELECT_B && AVS_BYTEENABLE[0])
      |=> PORT180_FUNCTION_CODE == $past(AVS_WRITEDATA[5:0]))
      else $error("port 180 code not taken from bits 5:0");
   chk_hi_b_write: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_WRITE && AVS_ADDRESS == OFS_SELECT_B && AVS_BYTEENABLE[1])
      |=> PORT181_FUNCTION_CODE == $past(AVS_WRITEDATA[13:8]))
      else $error("port 181 code not taken from bits 13:8");

   // cleared lanes and stray addresses leave the fields alone
   chk_lo_a_mask: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_WRITE && AVS_ADDRESS == OFS_SELECT_A && !AVS_BYTEENABLE[0])
      |=> $stable(PORT178_FUNCTION_CODE))
      else $error("port 178 code changed with lane 0 off");
   chk_hi_a_mask: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_WRITE && AVS_ADDRESS == OFS_SELECT_A && !AVS_BYTEENABLE[1])
      |=> $stable(PORT179_FUNCTION_CODE))
      else $error("port 179 code changed with lane 1 off");
   chk_lo_b_mask: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_WRITE && AVS_ADDRESS == OFS_SELECT_B && !AVS_BYTEENABLE[0])
      |=> $stable(PORT180_FUNCTION_CODE))
      else $error("port 180 code changed with lane 0 off");
   chk_hi_b_mask: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_WRITE && AVS_ADDRESS == OFS_SELECT_B && !AVS_BYTEENABLE[1])
      |=> $stable(PORT181_FUNCTION_CODE))
      else $error("port 181 code changed with lane 1 off");
   chk_stray_write: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_WRITE && reg_index(AVS_ADDRESS) == 2'h2)
      |=> $stable(PORT178_FUNCTION_CODE) && $stable(PORT179_FUNCTION_CODE)
       && $stable(PORT180_FUNCTION_CODE) && $stable(PORT181_FUNCTION_CODE))
      else $error("stray write changed a field");
   chk_fields_hold: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      !(req && AVS_WRITE) |=> $stable(PORT180_FUNCTION_CODE)
       && $stable(PORT181_FUNCTION_CODE) && $stable(PORT178_FUNCTION_CODE)
       && $stable(PORT179_FUNCTION_CODE))
      else $error("field changed without a write");

   // read path
   chk_zero_bits: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      !AVS_WAITREQUEST |-> AVS_READDATA[15:14] == 2'h0
       && AVS_READDATA[7:6] == 2'h0 && AVS_READDATA[31:16] == 16'h0000)
      else $error("unimplemented bits read nonzero");
   chk_read_back: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_READ && AVS_ADDRESS == OFS_SELECT_A)
      |=> AVS_READDATA[13:8] == $past(PORT179_FUNCTION_CODE)
       && AVS_READDATA[5:0] == $past(PORT178_FUNCTION_CODE))
      else $error("select_a read back wrong");
   chk_read_b: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_READ && AVS_ADDRESS == OFS_SELECT_B)
      |=> AVS_READDATA[13:8] == $past(PORT181_FUNCTION_CODE)
       && AVS_READDATA[5:0] == $past(PORT180_FUNCTION_CODE))
      else $error("select_b read back wrong");
   chk_stray_read: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_READ && reg_index(AVS_ADDRESS) == 2'h2)
      |=> AVS_READDATA == UNMAPPED_READ)
      else $error("stray read returned nonzero data");
   chk_rdata_hold: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      !(req && AVS_READ) |=> $stable(AVS_READDATA))
      else $error("read data changed without a read");

   // handshake and reset
   chk_one_wait: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      req |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("answer not one cycle after request");
   chk_write_ack: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      (req && AVS_WRITE) |=> !AVS_WAITREQUEST && $stable(AVS_READDATA))
      else $error("write not acknowledged cleanly");
   chk_wait_idle: assert property (
      @(posedge MCLK) disable iff (!rst_sync)
      !(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST)
      else $error("acknowledge without a request");
   chk_wait_reset: assert property (
      @(posedge MCLK)
      !rst_sync |-> AVS_WAITREQUEST && AVS_READDATA == 32'h0000_0000)
      else $error("bus outputs not idle in reset");
   chk_reset_codes: assert property (
      @(posedge MCLK)
      !rst_sync |-> PORT178_FUNCTION_CODE == CODE_RESET
       && PORT179_FUNCTION_CODE == CODE_RESET
       && PORT180_FUNCTION_CODE == CODE_RESET
       && PORT181_FUNCTION_CODE == CODE_RESET)
      else $error("function code not cleared by reset");
endmodule

// ### shared/vofs_pkg.sv
package vofs_pkg;
   localparam int          ADDR_W        = 4;
   localparam int          DATA_W        = 32;
   localparam int          CODE_W        = 6;
   localparam int          PORT_CNT      = 4;
   localparam logic [3:0]  OFS_SELECT_A  = 4'h0;
   localparam logic [3:0]  OFS_SELECT_B  = 4'h4;
   localparam int          LO_POS        = 0;
   localparam int          HI_POS        = 8;
   localparam logic [5:0]  CODE_RESET    = 6'h00;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// ### test/vofs_tb.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import vofs_pkg::*;
   logic              clk, rst_n, rd, wr, wait_req;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, got;
   logic [CODE_W-1:0] c178, c179, c180, c181;
   logic [3:0]        be;
   int                fail_count, samples_checked;
   vofs_top dut (.MCLK(clk), .ARST_N(rst_n), .AVS_ADDRESS(addr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
      .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wait_req), .PORT178_FUNCTION_CODE(c178),
      .PORT179_FUNCTION_CODE(c179), .PORT180_FUNCTION_CODE(c180),
      .PORT181_FUNCTION_CODE(c181));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] e = 4'hF);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      be    <= e;
      wr    <= w;
      rd    <= ~w;
      do @(posedge clk); while (wait_req !== 1'b0);
      got = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] act, input logic [31:0] exp);
      samples_checked++;
      if (act !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, act, exp);
      end
   endtask
   task automatic stop_test;
      $display("mismatches %0d of %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      stop_test();
   end
   initial begin
      {rst_n, rd, wr, addr, wdata, be, fail_count, samples_checked} = '0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (int r = 0; r < 2; r++) begin
         repeat (3) @(posedge clk);
         acc(0, OFS_SELECT_A, 0);
         chk(got, 32'h0);
         acc(0, OFS_SELECT_B, 0);
         chk(got, 32'h0);
         acc(1, OFS_SELECT_A, 32'hFFFF_FFFF);
         acc(0, OFS_SELECT_A, 0);
         chk(got, 32'h3F3F);
         acc(1, OFS_SELECT_A, 32'h0000_1205);
         chk({c179, c178}, 12'h485);
         acc(1, OFS_SELECT_B, 32'h0000_2A15);
         chk({c181, c180}, 12'hA95);
         acc(0, OFS_SELECT_B, 0);
         chk(got, 32'h2A15);
         acc(1, OFS_SELECT_B, 32'hFFFF_C0C0);
         acc(0, OFS_SELECT_B, 0);
         chk(got, 32'h0);
         acc(1, 4'h8, 32'hFFFF_FFFF);
         acc(0, 4'h8, 0);
         chk(got, UNMAPPED_READ);
         acc(0, OFS_SELECT_A, 0);
         chk(got, 32'h1205);
         // lane 0 only on select_a, lane 1 only on select_b
         acc(1, OFS_SELECT_A, 32'h0000_3F3F, 4'h1);
         chk({c179, c178}, 12'h4BF);
         acc(1, OFS_SELECT_B, 32'h0000_2A15, 4'h2);
         chk({c181, c180}, 12'hA80);
         acc(0, OFS_SELECT_B, 0);
         chk(got, 32'h2A00);
         rst_n <= 1'b0;
         @(posedge clk);
         chk({c179, c178}, 12'h0);
         chk({c181, c180}, 12'h0);
         rst_n <= 1'b1;
      end
      stop_test();
   end
endmodule
